// *** rtl/tpbs_top.sv ***
// Trigger prescaler, burst sequencer and eight-channel delay timer with APB registers
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tpbs_top #(
  parameter int TW = 50
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        TRIG_IN,
  input  wire logic        INHIBIT_IN,
  output logic             REFERENCE_OUTPUT_OUT,
  output logic             OUTPUT_PAIR_ONE_OUT,
  output logic             OUTPUT_PAIR_TWO_OUT,
  output logic             OUTPUT_PAIR_THREE_OUT,
  output logic             OUTPUT_PAIR_FOUR_OUT,
  output logic             TRIGGERED_INDICATOR_OUT,
  output logic             BURST_INDICATOR_OUT,
  output logic             RATE_OVERRUN_OUT,
  output logic             BLOCKED_TRIGGER_INDICATOR_OUT
);
  localparam int NC = tpbs_pkg::NUM_CH;
  localparam int NP = tpbs_pkg::NUM_PAIR;

  // Delay words need the 2000 s range in 5 ps steps and fit a 64-bit hi/lo pair
  if (TW < 49 || TW > 64) $error("TW must lie in 49..64");

  logic [tpbs_pkg::CTRL_W-1:0]       ctrl_r;
  logic [tpbs_pkg::TPRE_W-1:0]       tpre_r;
  logic [tpbs_pkg::TPRE_W-1:0]       tcnt_r;
  logic [31:0]                       hold_r;
  logic [31:0]                       hcnt_r;
  logic [31:0]                       bcnt_r;
  logic [31:0]                       bper_r;
  logic [31:0]                       per_r;
  logic [31:0]                       k_r;
  logic [TW-1:0]                     bdly_r;
  logic [TW-1:0]                     t_r;
  logic signed [TW-1:0]              off_r [NC];
  logic signed [TW-1:0]              abs_d [NC];
  logic [NC-1:0][3:0]                lnk_r;
  logic [NP-1:0][tpbs_pkg::OPRE_W-1:0] opre_r;
  logic [NP-1:0][tpbs_pkg::OPRE_W-1:0] oph_r;
  logic [NP-1:0][tpbs_pkg::OPRE_W-1:0] pcnt_r;
  logic [NP-1:0]                     pen_r;
  logic [NP-1:0]                     out_r;
  logic [NC-1:0]                     done;
  logic [1:0]                        tail_r;
  tpbs_pkg::tpbs_state_t             state_r;
  logic trigd_r, ovr_r, blk_r, ref_r, first_r, err_r;
  logic [31:0] prdata_r;

  wire adv      = ctrl_r[tpbs_pkg::CTRL_ADV];
  wire burst    = ctrl_r[tpbs_pkg::CTRL_BURST];
  wire ref_one  = ctrl_r[tpbs_pkg::CTRL_FIRST];
  wire single   = ctrl_r[tpbs_pkg::CTRL_SNGL];
  wire presc_on = adv & ~single;
  wire wr_acc   = PSEL_IN & PENABLE_IN & PWRITE_IN;

  // Address decode, shared by the read mux and the write processes
  logic [7:0] ch_rel;
  logic [7:0] pr_rel;
  logic [2:0] ci;
  logic [1:0] cw;
  logic [1:0] pi;
  logic       pw;
  logic       sel_ch;
  logic       sel_pr;
  always_comb
  begin
    ch_rel = PADDR_IN - tpbs_pkg::ADDR_CH_BASE;
    pr_rel = PADDR_IN - tpbs_pkg::ADDR_PR_BASE;
    ci     = 3'(ch_rel >> tpbs_pkg::CH_SH);
    cw     = 2'(ch_rel >> tpbs_pkg::WORD_SH);
    pi     = 2'(pr_rel >> tpbs_pkg::PR_SH);
    pw     = 1'(pr_rel >> tpbs_pkg::WORD_SH);
    sel_ch = (PADDR_IN >= tpbs_pkg::ADDR_CH_BASE) && (PADDR_IN < tpbs_pkg::ADDR_PR_BASE)
             && (cw <= tpbs_pkg::CW_LNK);
    sel_pr = (PADDR_IN >= tpbs_pkg::ADDR_PR_BASE) && (PADDR_IN < tpbs_pkg::ADDR_PR_END);
  end

  // Absolute delays resolved along link chains; NC passes cover the deepest chain
  always_comb
  begin
    for (int i = 0; i < NC; i++)
      abs_d[i] = off_r[i];
    for (int k = 0; k < NC; k++)
      for (int i = 0; i < NC; i++)
        abs_d[i] = off_r[i] + ((lnk_r[i] == tpbs_pkg::LINK_ZERO) ? '0
                   : abs_d[3'(lnk_r[i] - 4'h1)]);
  end

  // Walks the chain from the new target; meeting the channel itself means a loop
  function automatic logic link_loops(input logic [NC-1:0][3:0] lk,
                                      input logic [2:0] ch,
                                      input logic [3:0] tgt);
    logic [3:0] p;
    logic       hit;
    p   = tgt;
    hit = 1'b0;
    for (int s = 0; s < NC; s++)
    begin
      if (p == {1'b0, ch} + 4'h1)
        hit = 1'b1;
      if (p != tpbs_pkg::LINK_ZERO)
        p = lk[3'(p - 4'h1)];
    end
    return hit;
  endfunction

  wire [3:0] tgt      = PWDATA_IN[3:0];
  wire       lnk_wr   = wr_acc & sel_ch & (cw == tpbs_pkg::CW_LNK);
  wire       link_bad = (tgt > 4'(NC)) | link_loops(lnk_r, ci, tgt);
  wire signed [TW-1:0] tgt_abs = (tgt == tpbs_pkg::LINK_ZERO) ? '0 : abs_d[3'(tgt - 4'h1)];

  // Read mux; data is captured in the setup phase so it comes from a flop
  logic [31:0] rd_nxt;
  logic        map_ok;
  always_comb
  begin
    rd_nxt = '0;
    map_ok = 1'b1;
    if (PADDR_IN == tpbs_pkg::ADDR_CTRL)
      rd_nxt = 32'(ctrl_r);
    else if (PADDR_IN == tpbs_pkg::ADDR_STAT)
      rd_nxt = {29'h0, state_r != tpbs_pkg::ST_IDLE, burst, trigd_r};
    else if (PADDR_IN == tpbs_pkg::ADDR_TPRE)
      rd_nxt = 32'(tpre_r);
    else if (PADDR_IN == tpbs_pkg::ADDR_HOLD)
      rd_nxt = hold_r;
    else if (PADDR_IN == tpbs_pkg::ADDR_BCNT)
      rd_nxt = bcnt_r;
    else if (PADDR_IN == tpbs_pkg::ADDR_BPER)
      rd_nxt = bper_r;
    else if (PADDR_IN == tpbs_pkg::ADDR_BDLY_LO)
      rd_nxt = bdly_r[31:0];
    else if (PADDR_IN == tpbs_pkg::ADDR_BDLY_HI)
      rd_nxt = 32'(bdly_r[TW-1:32]);
    else if (sel_ch && cw == tpbs_pkg::CW_LO)
      rd_nxt = off_r[ci][31:0];
    else if (sel_ch && cw == tpbs_pkg::CW_HI)
      rd_nxt = 32'(off_r[ci][TW-1:32]);
    else if (sel_ch)
      rd_nxt = 32'(lnk_r[ci]);
    else if (sel_pr && !pw)
      rd_nxt = 32'(opre_r[pi]);
    else if (sel_pr)
      rd_nxt = 32'(oph_r[pi]);
    else
      map_ok = 1'b0;
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      prdata_r <= '0;
      err_r    <= 1'b0;
    end
    else if (PSEL_IN && !PENABLE_IN)
    begin
      prdata_r <= rd_nxt;
      err_r    <= ~map_ok;
    end
  end

  // Zero-wait slave; a refused link write answers with an error
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & (err_r | (lnk_wr & link_bad));
  assign PRDATA_OUT  = prdata_r;

  // Global settings; zero counts are stored as one so dividers never stall
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      ctrl_r <= tpbs_pkg::CTRL_RST;
      tpre_r <= tpbs_pkg::TPRE_RST;
      hold_r <= '0;
      bcnt_r <= tpbs_pkg::ONE_RST;
      bper_r <= tpbs_pkg::ONE_RST;
      bdly_r <= '0;
    end
    else if (wr_acc)
    begin
      if (PADDR_IN == tpbs_pkg::ADDR_CTRL)
        ctrl_r <= PWDATA_IN[tpbs_pkg::CTRL_W-1:0];
      else if (PADDR_IN == tpbs_pkg::ADDR_TPRE)
        tpre_r <= (PWDATA_IN[tpbs_pkg::TPRE_W-1:0] == '0) ? tpbs_pkg::TPRE_RST
                  : PWDATA_IN[tpbs_pkg::TPRE_W-1:0];
      else if (PADDR_IN == tpbs_pkg::ADDR_HOLD)
        hold_r <= PWDATA_IN;
      else if (PADDR_IN == tpbs_pkg::ADDR_BCNT)
        bcnt_r <= (PWDATA_IN == '0) ? tpbs_pkg::ONE_RST : PWDATA_IN;
      else if (PADDR_IN == tpbs_pkg::ADDR_BPER)
        bper_r <= (PWDATA_IN == '0) ? tpbs_pkg::ONE_RST : PWDATA_IN;
      else if (PADDR_IN == tpbs_pkg::ADDR_BDLY_LO)
        bdly_r[31:0] <= PWDATA_IN;
      else if (PADDR_IN == tpbs_pkg::ADDR_BDLY_HI)
        bdly_r[TW-1:32] <= PWDATA_IN[TW-33:0];
    end
  end

  // Channel offsets and links; relinking rewrites the offset, not the delay
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      for (int i = 0; i < NC; i++)
        off_r[i] <= '0;
      lnk_r <= '0;
    end
    else if (wr_acc && sel_ch)
    begin
      if (cw == tpbs_pkg::CW_LO)
        off_r[ci][31:0] <= PWDATA_IN;
      else if (cw == tpbs_pkg::CW_HI)
        off_r[ci][TW-1:32] <= PWDATA_IN[TW-33:0];
      else if (!link_bad)
      begin
        lnk_r[ci] <= tgt;
        off_r[ci] <= abs_d[ci] - tgt_abs;
      end
    end
  end

  // Output pair prescale and phase settings
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      opre_r <= {NP{tpbs_pkg::OPRE_RST}};
      oph_r  <= '0;
    end
    else if (wr_acc && sel_pr)
    begin
      if (!pw)
        opre_r[pi] <= (PWDATA_IN[tpbs_pkg::OPRE_W-1:0] == '0) ? tpbs_pkg::OPRE_RST
                      : PWDATA_IN[tpbs_pkg::OPRE_W-1:0];
      else
        oph_r[pi] <= PWDATA_IN[tpbs_pkg::OPRE_W-1:0];
    end
  end

  // Trigger qualification
  wire busy      = state_r != tpbs_pkg::ST_IDLE;
  wire blocked   = TRIG_IN & (INHIBIT_IN | wr_acc);
  wire hold_left = adv & (hcnt_r < hold_r);
  wire overrun   = TRIG_IN & ~blocked & (busy | hold_left);
  wire accept    = TRIG_IN & ~blocked & ~busy & ~hold_left;
  wire launch    = accept & (~presc_on | (tcnt_r == tpre_r - 1'b1));

  // Trigger prescaler and holdoff timer
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      tcnt_r <= '0;
      hcnt_r <= '1;
    end
    else
    begin
      if (accept)
        tcnt_r <= launch ? '0 : tcnt_r + 1'b1;
      if (accept)
        hcnt_r <= '0;
      else if (hcnt_r != '1)
        hcnt_r <= hcnt_r + 1'b1;
    end
  end

  // Status flags; a new accept wins over the clear
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      trigd_r <= 1'b0;
      ovr_r   <= 1'b0;
      blk_r   <= 1'b0;
    end
    else
    begin
      trigd_r <= accept | (trigd_r & busy);
      ovr_r   <= overrun;
      blk_r   <= blocked;
    end
  end

  // Channel expiry against elapsed cycle time, 5 ps units
  for (genvar g = 0; g < NC; g++)
  begin : g_done
    assign done[g] = $signed({1'b0, t_r}) >= (TW + 1)'(abs_d[g]);
  end

  wire all_done  = &done;
  wire cyc_end   = all_done & (tail_r >= 2'(tpbs_pkg::REF_TAIL_CYC)) & ~hold_left;
  wire more      = burst & (k_r < bcnt_r);
  wire wait_over = t_r >= (burst ? bdly_r : '0);
  wire gap_over  = per_r >= bper_r - 1'b1;
  wire start     = (state_r == tpbs_pkg::ST_WAIT && wait_over)
                 | (state_r == tpbs_pkg::ST_GAP && gap_over);

  // Burst and delay cycle sequencer
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      state_r <= tpbs_pkg::ST_IDLE;
      t_r     <= '0;
      per_r   <= '0;
      k_r     <= '0;
      tail_r  <= '0;
      first_r <= 1'b0;
    end
    else
    begin
      per_r <= per_r + 1'b1;
      case (state_r)
        tpbs_pkg::ST_IDLE:
        begin
          if (launch)
          begin
            state_r <= tpbs_pkg::ST_WAIT;
            t_r     <= '0;
            k_r     <= '0;
          end
        end
        tpbs_pkg::ST_WAIT:
        begin
          t_r <= t_r + TW'(tpbs_pkg::STEP_PER_CLK);
        end
        tpbs_pkg::ST_RUN:
        begin
          t_r <= t_r + TW'(tpbs_pkg::STEP_PER_CLK);
          if (all_done && tail_r != 2'h3)
            tail_r <= tail_r + 2'h1;
          if (cyc_end)
            state_r <= more ? tpbs_pkg::ST_GAP : tpbs_pkg::ST_IDLE;
        end
        default:
        begin
        end
      endcase
      if (start)
      begin
        state_r <= tpbs_pkg::ST_RUN;
        t_r     <= '0;
        per_r   <= '0;
        tail_r  <= '0;
        k_r     <= k_r + 1'b1;
        first_r <= k_r == '0;
      end
    end
  end

  // Pair prescalers count delay cycles and latch their enable at cycle start
  for (genvar p = 0; p < NP; p++)
  begin : g_pair
    always_ff @(posedge CLK_SYS_IN)
    begin
      if (RST_IN)
      begin
        pcnt_r[p] <= '0;
        pen_r[p]  <= 1'b0;
      end
      else if (start)
      begin
        pen_r[p]  <= ~presc_on | (pcnt_r[p] == oph_r[p]);
        pcnt_r[p] <= (pcnt_r[p] >= opre_r[p] - 1'b1) ? '0 : pcnt_r[p] + 1'b1;
      end
    end
  end

  // Pulse outputs; all share the same one-cycle register delay
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RST_IN)
    begin
      out_r <= '0;
      ref_r <= 1'b0;
    end
    else
    begin
      for (int p = 0; p < NP; p++)
        out_r[p] <= (state_r == tpbs_pkg::ST_RUN) & pen_r[p]
                    & done[2*p] & ~done[2*p+1];
      ref_r <= (state_r == tpbs_pkg::ST_RUN) & ~cyc_end
               & (~burst | ~ref_one | first_r);
    end
  end

  assign REFERENCE_OUTPUT_OUT          = ref_r;
  assign OUTPUT_PAIR_ONE_OUT           = out_r[0];
  assign OUTPUT_PAIR_TWO_OUT           = out_r[1];
  assign OUTPUT_PAIR_THREE_OUT         = out_r[2];
  assign OUTPUT_PAIR_FOUR_OUT          = out_r[3];
  assign TRIGGERED_INDICATOR_OUT       = trigd_r;
  assign BURST_INDICATOR_OUT           = burst;
  assign RATE_OVERRUN_OUT              = ovr_r;
  assign BLOCKED_TRIGGER_INDICATOR_OUT = blk_r;

  // Checks next to the logic they guard
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  sequence s_tail_start;
    state_r == tpbs_pkg::ST_RUN && all_done && tail_r == 2'h0;
  endsequence
  sequence s_tail_hold;
    (state_r == tpbs_pkg::ST_RUN)[*3];
  endsequence

  ovr_pulse_a: assert property (TRIG_IN && !INHIBIT_IN && !wr_acc && busy
    |=> RATE_OVERRUN_OUT && !BLOCKED_TRIGGER_INDICATOR_OUT)
    else $error("overrun not flagged");
  blk_pulse_a: assert property (TRIG_IN && INHIBIT_IN
    |=> BLOCKED_TRIGGER_INDICATOR_OUT && !RATE_OVERRUN_OUT)
    else $error("inhibited trigger not flagged");
  burst_ind_a: assert property (wr_acc && PADDR_IN == tpbs_pkg::ADDR_CTRL
    |=> BURST_INDICATOR_OUT == $past(PWDATA_IN[tpbs_pkg::CTRL_BURST]))
    else $error("burst indicator wrong");
  trigd_set_a: assert property (accept |=> TRIGGERED_INDICATOR_OUT)
    else $error("triggered not set");
  trigd_clr_a: assert property (!busy && !accept |=> !TRIGGERED_INDICATOR_OUT)
    else $error("triggered not cleared");
  ref_tail_a: assert property (s_tail_start |=> s_tail_hold)
    else $error("reference tail too short");
  pair_edge_a: assert property (state_r == tpbs_pkg::ST_RUN && pen_r[0]
    && done[0] && !done[1] |=> OUTPUT_PAIR_ONE_OUT)
    else $error("pair one not high between edges");
  presc_skip_a: assert property (accept && presc_on && tcnt_r != tpre_r - 1'b1
    |=> state_r == tpbs_pkg::ST_IDLE)
    else $error("prescaled trigger launched");
  sngl_bypass_a: assert property (accept && single |=> state_r == tpbs_pkg::ST_WAIT)
    else $error("single shot not launched");
  link_refuse_a: assert property (lnk_wr && link_bad |=> lnk_r == $past(lnk_r))
    else $error("circular link taken");
  burst_more_a: assert property (state_r == tpbs_pkg::ST_RUN && cyc_end && more
    |=> state_r == tpbs_pkg::ST_GAP)
    else $error("burst ended early");
endmodule
`default_nettype wire

// *** rtl/tpbs_pkg.sv ***
// Constants, register map and timing for the trigger prescale burst delay sequencer
package tpbs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RES_PS        = 5;
  localparam int unsigned STEP_PER_CLK  = CLK_PERIOD_NS * 1000 / RES_PS;
  localparam int unsigned REF_TAIL_NS   = 25;
  localparam int unsigned REF_TAIL_CYC  = (REF_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NUM_CH        = 8;
  localparam int unsigned NUM_PAIR      = 4;
  localparam int unsigned TPRE_W        = 30;
  localparam int unsigned OPRE_W        = 16;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STAT    = 8'h04;
  localparam logic [7:0] ADDR_TPRE    = 8'h08;
  localparam logic [7:0] ADDR_HOLD    = 8'h0c;
  localparam logic [7:0] ADDR_BCNT    = 8'h10;
  localparam logic [7:0] ADDR_BPER    = 8'h14;
  localparam logic [7:0] ADDR_BDLY_LO = 8'h18;
  localparam logic [7:0] ADDR_BDLY_HI = 8'h1c;
  localparam logic [7:0] ADDR_CH_BASE = 8'h40;
  localparam logic [7:0] ADDR_PR_BASE = 8'hc0;
  localparam logic [7:0] ADDR_PR_END  = 8'he0;
  localparam int unsigned CH_SH   = 4;
  localparam int unsigned PR_SH   = 3;
  localparam int unsigned WORD_SH = 2;
  localparam logic [1:0] CW_LO  = 2'h0;
  localparam logic [1:0] CW_HI  = 2'h1;
  localparam logic [1:0] CW_LNK = 2'h2;
  localparam int unsigned CTRL_ADV   = 0;
  localparam int unsigned CTRL_BURST = 1;
  localparam int unsigned CTRL_FIRST = 2;
  localparam int unsigned CTRL_SNGL  = 3;
  localparam int unsigned CTRL_W     = 4;
  localparam logic [3:0] LINK_ZERO = 4'h0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [TPRE_W-1:0] TPRE_RST = 30'h1;
  localparam logic [OPRE_W-1:0] OPRE_RST = 16'h1;
  localparam logic [31:0]       ONE_RST  = 32'h1;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN, ST_GAP} tpbs_state_t;
endpackage

// *** tb/tpbs_partner.sv ***
// Trigger source and pulse-counting instrument on the far side of the sequencer
`timescale 1ns/100ps
`default_nettype none
module tpbs_partner (
  input  wire logic clk_in,
  input  wire logic ref_in,
  input  wire logic pair_in,
  input  wire logic ovr_in,
  input  wire logic blk_in,
  output logic      trig_out,
  output logic      inh_out
);
  int   cyc    = 0;
  int   n_ref  = 0;
  int   n_pair = 0;
  int   n_ovr  = 0;
  int   n_blk  = 0;
  int   run    = 0;
  int   width  = 0;
  int   gap    = 0;
  int   t_ref  = 0;
  int   t_trig = 0;
  logic ref_d  = 1'b0;
  logic pair_d = 1'b0;

  // Idle source: no trigger and no inhibit until asked
  initial
  begin
    trig_out = 1'b0;
    inh_out  = 1'b0;
  end

  // Instruments count rising edges of ref and pair, high cycles of ovr and blk, and the spacing of ref edges and the width of pair pulses
  always @(posedge clk_in)
  begin
    cyc    <= cyc + 1;
    ref_d  <= ref_in;
    pair_d <= pair_in;
    n_ovr  <= n_ovr + int'(ovr_in);
    n_blk  <= n_blk + int'(blk_in);
    if (ref_in && !ref_d)
    begin
      n_ref <= n_ref + 1;
      gap   <= cyc - t_ref;
      t_ref <= cyc;
    end
    if (pair_in && !pair_d)
      n_pair <= n_pair + 1;
    run <= pair_in ? run + 1 : 0;
    if (!pair_in && pair_d)
      width <= run;
  end

  // One-cycle trigger pulse, edge already chosen upstream
  task automatic fire();
    @(posedge clk_in);
    trig_out <= 1'b1;
    t_trig   <= cyc;
    @(posedge clk_in);
    trig_out <= 1'b0;
  endtask

  task automatic set_inh(input logic v);
    @(posedge clk_in);
    inh_out <= v;
  endtask

  // Cleared off the edge so the counting process never races it
  task automatic clr();
    @(posedge clk_in);
    #1;
    n_ref  = 0;
    n_pair = 0;
    n_ovr  = 0;
    n_blk  = 0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the trigger prescale burst delay sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig;
  logic        blocked_trigger_indicator;
  logic        ref_o;
  logic        p1;
  logic        p2;
  logic        p3;
  logic        p4;
  logic        tind;
  logic        bst;
  logic        ovr;
  logic        blk;
  int          fails       = 0;
  int          checks_done = 0;
  int          d0;

  tpbs_top uut (.CLK_SYS_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TRIG_IN(trig), .INHIBIT_IN(blocked_trigger_indicator),
    .REFERENCE_OUTPUT_OUT(ref_o), .OUTPUT_PAIR_ONE_OUT(p1), .OUTPUT_PAIR_TWO_OUT(p2),
    .OUTPUT_PAIR_THREE_OUT(p3), .OUTPUT_PAIR_FOUR_OUT(p4), .TRIGGERED_INDICATOR_OUT(tind),
    .BURST_INDICATOR_OUT(bst), .RATE_OVERRUN_OUT(ovr), .BLOCKED_TRIGGER_INDICATOR_OUT(blk));

  tpbs_partner partner (.clk_in(clk), .ref_in(ref_o), .pair_in(p1), .ovr_in(ovr),
    .blk_in(blk), .trig_out(trig), .inh_out(blocked_trigger_indicator));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Setup then access, held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask

  task automatic shots(input int n);
    repeat (n)
    begin
      partner.fire();
      repeat (40) @(posedge clk);
    end
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h1);
    rd(8'h10, 32'h1);
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk(e, 1'b1);
    chk(bst, 1'b0);
  endtask

  task automatic t_basic();
    partner.clr();
    partner.fire();
    repeat (2) @(posedge clk);
    chk(tind, 1'b1);
    partner.fire();
    repeat (40) @(posedge clk);
    chk(tind, 1'b0);
    chk(partner.n_ref, 1);
    chk(partner.n_ovr, 1);
    partner.set_inh(1'b1);
    partner.fire();
    partner.set_inh(1'b0);
    repeat (40) @(posedge clk);
    chk(partner.n_blk, 1);
    chk(partner.n_ref, 1);
  endtask

  task automatic t_prescale();
    logic [31:0] ctl [3] = '{32'h1, 32'h9, 32'h0};
    int          exp [3] = '{2, 6, 6};
    wr(8'h08, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h00, ctl[i]);
      partner.clr();
      shots(6);
      chk(partner.n_ref, exp[i]);
    end
  endtask

  task automatic t_pairs();
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h1);
    wr(8'h40, 32'h0000_0fa0);
    wr(8'h58, 32'h1);
    wr(8'h50, 32'h0000_0fa0);
    wr(8'h54, 32'h0); // Relink left a negative high word behind
    wr(8'hc0, 32'h2);
    wr(8'hc4, 32'h1);
    partner.clr();
    for (int k = 0; k < 4; k++)
    begin
      shots(1);
      chk(partner.n_pair, (k + 1) / 2);
    end
    chk(partner.width, 2);
    chk({p2, p3, p4}, 3'h0);
  endtask

  task automatic t_links();
    logic [31:0] q;
    logic        e;
    apb(1'b1, 8'h48, 32'h2, q, e);
    chk(e, 1'b1);
    rd(8'h48, 32'h0);
    wr(8'h58, 32'h0);
    rd(8'h50, 32'h0000_1f40);
  endtask

  task automatic t_burst();
    wr(8'h00, 32'h2);
    @(posedge clk);
    chk(bst, 1'b1);
    wr(8'h10, 32'h3);
    wr(8'h14, 32'd20);
    partner.clr();
    partner.fire();
    repeat (5) @(posedge clk);
    partner.fire();
    repeat (100) @(posedge clk);
    chk(partner.n_ref, 3);
    chk(partner.gap, 20);
    chk(partner.n_ovr, 1);
    wr(8'h00, 32'h6);
    partner.clr();
    partner.fire();
    repeat (60) @(posedge clk);
    chk(partner.n_ref, 1);
    wr(8'h00, 32'h2);
    wr(8'h10, 32'h1);
    shots(1);
    d0 = partner.t_ref - partner.t_trig;
    wr(8'h18, 32'h0000_4e20);
    shots(1);
    chk(partner.t_ref - partner.t_trig - d0, 10);
    wr(8'h00, 32'h0);
    @(posedge clk);
    chk(bst, 1'b0);
  endtask

  task automatic t_holdoff();
    wr(8'h00, 32'h1);
    wr(8'h0c, 32'd60);
    partner.clr();
    partner.fire();
    repeat (30) @(posedge clk);
    partner.fire();
    repeat (60) @(posedge clk);
    partner.fire();
    repeat (80) @(posedge clk);
    chk(partner.n_ovr, 1);
    chk(partner.n_ref, 2);
  endtask

  // Reset for 8 cycles, then the scenarios in turn
  initial
  begin
    rst    = 1'b1;
    psel   = 1'b0;
    pen    = 1'b0;
    pwr    = 1'b0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_basic();
    t_prescale();
    t_pairs();
    t_links();
    t_burst();
    t_holdoff();
    end_sim();
  end

  // Scenarios need about 1600 cycles; a hang stops well past that
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
